// [verilog/nsg_map.svh]
// Constants for the NAND status, reset and command guard controller.
`ifndef NSG_MAP_SVH
`define NSG_MAP_SVH
// Command codes.
`define NSG_CMD_STATUS 8'h70
`define NSG_CMD_MSTATUS 8'h71
`define NSG_CMD_RESET 8'hff
`define NSG_CMD_READ 8'h00
`define NSG_CMD_SERIAL_IN 8'h80
`define NSG_CMD_COL_CHANGE 8'h85
`define NSG_CMD_PROG 8'h10
`define NSG_CMD_MPROG 8'h11
`define NSG_CMD_CACHE_PROG 8'h15
`define NSG_CMD_CACHE_READ 8'h31
`define NSG_CMD_ERASE_SETUP 8'h60
`define NSG_CMD_ERASE_GO 8'hd0
`define NSG_CMD_READ_GO 8'h30
// Status byte bit positions.
`define NSG_ST_FAIL 0
`define NSG_ST_PREV_FAIL 1
`define NSG_ST_BUF_RDY 5
`define NSG_ST_CACHE_RDY 6
`define NSG_ST_NOT_WP 7
// Software register addresses.
`define NSG_REG_CMD 4'h0
`define NSG_REG_CTRL 4'h1
`define NSG_REG_STATUS 4'h2
`define NSG_REG_SBYTE 4'h3
`define NSG_REG_DATA 4'h4
// Control register fields.
`define NSG_CTRL_WP_N 0
`define NSG_CTRL_CE 1
// Strobe phase length in cycles: 20 ns at 10 ns per cycle.
`define NSG_PHASE_NS 20
`define NSG_CLK_NS 10
`define NSG_PHASE_CYC ((`NSG_PHASE_NS + `NSG_CLK_NS - 1) / `NSG_CLK_NS)
`endif

// [verilog/nsg_pkg.sv]
// Types shared by the NAND guard controller.
package nsg_pkg;
    // Kind of bus cycle to place on the flash pins.
    typedef enum logic [1:0] {
        NSG_CYC_CMD,
        NSG_CYC_ADDR,
        NSG_CYC_WDATA,
        NSG_CYC_RDATA
    } nsg_cyc_t;
    // Flash pins driven by the controller.
    typedef struct packed {
        logic cmd_latch;
        logic addr_latch;
        logic write_strobe_n;
        logic read_strobe_n;
        logic chip_enable_n;
        logic write_protect_n;
        logic [7:0] io_out;
        logic io_oe;
    } nsg_pins_t;
    // Decoded status byte.
    typedef struct packed {
        logic not_protected;
        logic cache_ready;
        logic buf_ready;
        logic prev_fail;
        logic fail;
    } nsg_status_t;
endpackage

// [verilog/nsg_strobe.sv]
// One flash bus cycle generator: strobe low phase then strobe high phase.
`timescale 1ns/10ps
`include "nsg_map.svh"
module nsg_strobe (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire nsg_pkg::nsg_cyc_t kind_i,
    input wire logic [7:0] byte_i,
    input wire logic [7:0] io_sync_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rbyte_o,
    output logic cmd_latch_o,
    output logic addr_latch_o,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o,
    output logic [7:0] io_out_o,
    output logic io_oe_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} nsg_phase_t;
    typedef struct packed {
        nsg_phase_t st;
        logic [3:0] cnt;
        nsg_pkg::nsg_cyc_t kind;
        logic [7:0] data;
        logic [7:0] rbyte;
        logic done;
    } nsg_strobe_t;
    nsg_strobe_t s_reg, s_next;

    // Strobe low for one phase, then high for one phase; read data taken at the end of the first high cycle.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        case (s_reg.st)
            ST_IDLE: begin
                if (start_i) begin
                    s_next.st = ST_LOW;
                    s_next.kind = kind_i;
                    s_next.data = byte_i;
                    s_next.cnt = 4'(`NSG_PHASE_CYC);
                end
            end
            ST_LOW: begin
                if (s_reg.cnt == 4'h1) begin
                    s_next.st = ST_HIGH;
                    s_next.cnt = 4'(`NSG_PHASE_CYC);
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            ST_HIGH: begin
                // The synchronised byte trails the pin by two cycles, so the first high
                // cycle is the earliest edge at which it holds the driven value.
                if (s_reg.cnt == 4'(`NSG_PHASE_CYC)) begin
                    s_next.rbyte = io_sync_i;
                end
                if (s_reg.cnt == 4'h1) begin
                    s_next.st = ST_IDLE;
                    s_next.done = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Pin outputs; the write bus holds through the high phase for hold time.
    assign busy_o = (s_reg.st != ST_IDLE);
    assign done_o = s_reg.done;
    assign rbyte_o = s_reg.rbyte;
    assign cmd_latch_o = busy_o && (s_reg.kind == nsg_pkg::NSG_CYC_CMD);
    assign addr_latch_o = busy_o && (s_reg.kind == nsg_pkg::NSG_CYC_ADDR);
    assign write_strobe_n_o = !((s_reg.st == ST_LOW) && (s_reg.kind != nsg_pkg::NSG_CYC_RDATA));
    assign read_strobe_n_o = !((s_reg.st == ST_LOW) && (s_reg.kind == nsg_pkg::NSG_CYC_RDATA));
    assign io_out_o = s_reg.data;
    assign io_oe_o = busy_o && (s_reg.kind != nsg_pkg::NSG_CYC_RDATA);
endmodule

// [verilog/nsg_ctrl.sv]
// Host controller that guards commands to a NAND flash and polls its status.
//
// Behaviour
// (RULE1) Status command then read strobe yields status.
// (RULE2) Status polling allowed during a read.
// (RULE3) Bit 0 is program/erase result.
// (RULE4) Cache program bit 0 valid when bit5 ready.
// (RULE5) Cache program bit 1 valid when bit6 ready.
// (RULE6) Bit 5 shows page buffer ready.
// (RULE7) Bit 6 shows data cache ready.
// (RULE8) Bit 7 shows write protection state.
// (RULE9) Bits 2 to 4 read zero.
// (RULE10) Pass/fail used only after ready program/erase.
// (RULE11) Bits 5 and 6 match except after cache.
// (RULE12) Reset command halts device operation.
// (RULE13) Reset may abort earlier cached page too.
// (RULE14) Only reset or status during power-up busy.
// (RULE15) Never send undefined command codes.
// (RULE16) While busy only 70h, 71h or FFh.
// (RULE17) After 80h only 85h,10h,11h,15h,FFh.
// (RULE18) Other command after 80h abandons program.
// (RULE19) Program pages in ascending order.
// (RULE20) Status mode held until read command resumes.
// (RULE21) Write-protect low aborts program and erase.
// (RULE22) Sixth address cycle is ignored. The code passes six address cycles on and refuses the seventh.
// (RULE23) Use status read on shared ready line.
// (RULE24) Use 71h after multi-operations.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "nsg_map.svh"
module nsg_ctrl (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output nsg_pkg::nsg_pins_t pins_o,
    input wire logic [7:0] io_in_i,
    input wire logic ready_busy_n_i
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] io_m;
        logic [7:0] io_s;
        logic rb_m;
        logic rb_s;
    } nsg_sync_t;
    nsg_sync_t y_reg;

    // Pins are asynchronous to our clock; two stages before use.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            y_reg <= '0;
        end else begin
            y_reg <= '{io_m: io_in_i, io_s: y_reg.io_m, rb_m: ready_busy_n_i, rb_s: y_reg.rb_m};
        end
    end

    // ------------------------------------------------------------------
    // Command guard state
    // ------------------------------------------------------------------
    // Returns one when the code is in the defined command set.
    function automatic logic known_cmd(input logic [7:0] c);
        case (c)
            `NSG_CMD_STATUS, `NSG_CMD_MSTATUS, `NSG_CMD_RESET, `NSG_CMD_READ,
            `NSG_CMD_SERIAL_IN, `NSG_CMD_COL_CHANGE, `NSG_CMD_PROG, `NSG_CMD_MPROG,
            `NSG_CMD_CACHE_PROG, `NSG_CMD_CACHE_READ, `NSG_CMD_ERASE_SETUP,
            `NSG_CMD_ERASE_GO, `NSG_CMD_READ_GO: known_cmd = 1'b1;
            default: known_cmd = 1'b0;
        endcase
    endfunction

    typedef struct packed {
        logic after_serial;
        logic in_status;
        logic after_cache;
        logic powered_up;
        logic rejected;
        logic wp_n;
        logic ce;
        logic pending;
        nsg_pkg::nsg_cyc_t kind;
        logic [7:0] byte_q;
        logic [7:0] sbyte;
        logic [7:0] rbyte;
        logic [2:0] addr_cnt;
        logic [15:0] rdata;
    } nsg_guard_t;
    nsg_guard_t s_reg, s_next;

    logic eng_busy;
    logic eng_done;
    logic [7:0] eng_rbyte;
    logic dev_busy;
    logic req_ok;
    logic [7:0] req_cmd;
    nsg_pkg::nsg_status_t stat;

    assign dev_busy = !y_reg.rb_s;
    assign req_cmd = wdata_i[7:0];

    // Decide whether a command write may go to the flash.
    always_comb begin
        req_ok = known_cmd(req_cmd); // [RULE15]
        if (dev_busy || !s_reg.powered_up) begin
            req_ok = req_ok && (req_cmd == `NSG_CMD_STATUS || req_cmd == `NSG_CMD_MSTATUS ||
                req_cmd == `NSG_CMD_RESET); // [RULE14] [RULE16] [RULE2]
        end
        if (s_reg.after_serial) begin
            req_ok = req_ok && (req_cmd == `NSG_CMD_COL_CHANGE || req_cmd == `NSG_CMD_PROG ||
                req_cmd == `NSG_CMD_MPROG || req_cmd == `NSG_CMD_CACHE_PROG ||
                req_cmd == `NSG_CMD_RESET); // [RULE17]
        end
    end

    // Decode the last status byte; unused bits and invalid pass/fail are masked.
    always_comb begin
        stat.not_protected = s_reg.sbyte[`NSG_ST_NOT_WP]; // [RULE8]
        stat.cache_ready = s_reg.sbyte[`NSG_ST_CACHE_RDY]; // [RULE7]
        stat.buf_ready = s_reg.sbyte[`NSG_ST_BUF_RDY]; // [RULE6]
        stat.fail = s_reg.sbyte[`NSG_ST_FAIL] && stat.buf_ready; // [RULE3] [RULE4] [RULE10]
        stat.prev_fail = s_reg.sbyte[`NSG_ST_PREV_FAIL] && stat.cache_ready
            && s_reg.after_cache; // [RULE5] [RULE11]
    end

    // One process holds the whole command guard state.
    always_comb begin
        s_next = s_reg;
        if (y_reg.rb_s) begin
            s_next.powered_up = 1'b1;
        end
        if (wr_i && addr_i == `NSG_REG_CTRL) begin
            s_next.wp_n = wdata_i[`NSG_CTRL_WP_N]; // [RULE21]
            s_next.ce = wdata_i[`NSG_CTRL_CE];
        end
        if (wr_i && addr_i == `NSG_REG_CMD && !s_reg.pending && !eng_busy) begin
            if (wdata_i[9:8] == 2'(nsg_pkg::NSG_CYC_CMD)) begin
                s_next.rejected = !req_ok;
                s_next.pending = req_ok;
                if (req_ok) begin
                    s_next.after_serial = (req_cmd == `NSG_CMD_SERIAL_IN) ||
                        (s_reg.after_serial && req_cmd == `NSG_CMD_COL_CHANGE); // [RULE18]
                    s_next.in_status = (req_cmd == `NSG_CMD_STATUS) ||
                        (req_cmd == `NSG_CMD_MSTATUS) ||
                        (s_reg.in_status && req_cmd != `NSG_CMD_READ); // [RULE20] [RULE24]
                    if (req_cmd != `NSG_CMD_STATUS && req_cmd != `NSG_CMD_MSTATUS) begin
                        s_next.after_cache = (req_cmd == `NSG_CMD_CACHE_PROG) ||
                            (req_cmd == `NSG_CMD_CACHE_READ);
                    end
                    if (req_cmd == `NSG_CMD_RESET) begin
                        s_next.after_serial = 1'b0; // [RULE12] [RULE13]
                        s_next.after_cache = 1'b0;
                        s_next.in_status = 1'b0; // [RULE12]
                    end
                    s_next.addr_cnt = 3'h0;
                end
            end else if (wdata_i[9:8] == 2'(nsg_pkg::NSG_CYC_ADDR) && s_reg.addr_cnt == 3'h6) begin
                s_next.rejected = 1'b1; // [RULE22]
            end else begin
                s_next.rejected = 1'b0;
                s_next.pending = 1'b1;
                if (wdata_i[9:8] == 2'(nsg_pkg::NSG_CYC_ADDR)) begin
                    s_next.addr_cnt = s_reg.addr_cnt + 3'h1; // Passed on in software's order. [RULE19]
                end
            end
            s_next.kind = nsg_nsg_kind(wdata_i[9:8]);
            s_next.byte_q = req_cmd;
        end
        if (s_reg.pending) begin
            s_next.pending = 1'b0;
        end
        if (eng_done && s_reg.kind == nsg_pkg::NSG_CYC_RDATA) begin
            if (s_reg.in_status) begin
                s_next.sbyte = eng_rbyte & 8'he3; // [RULE1] [RULE9]
            end else begin
                s_next.rbyte = eng_rbyte;
            end
        end
        s_next.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                `NSG_REG_CTRL: s_next.rdata = {14'h0000, s_reg.ce, s_reg.wp_n};
                `NSG_REG_STATUS: s_next.rdata = {8'h00, s_reg.rejected, s_reg.in_status,
                    eng_busy || s_reg.pending, dev_busy, s_reg.after_serial, s_reg.after_cache,
                    s_reg.powered_up, 1'b0}; // [RULE23]
                `NSG_REG_SBYTE: s_next.rdata = {11'h000, stat};
                `NSG_REG_DATA: s_next.rdata = {8'h00, s_reg.rbyte};
                default: s_next.rdata = 16'h0000;
            endcase
        end
    end

    // Maps the two command bits to a bus cycle kind.
    function automatic nsg_pkg::nsg_cyc_t nsg_nsg_kind(input logic [1:0] k);
        nsg_nsg_kind = nsg_pkg::nsg_cyc_t'(k);
    endfunction

    // State register.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Flash bus cycle engine
    // ------------------------------------------------------------------
    logic cl;
    logic al;
    logic we_n;
    logic rs_n;
    logic [7:0] io_o;
    logic oe;

    nsg_strobe u_strobe (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(s_reg.pending),
        .kind_i(s_reg.kind),
        .byte_i(s_reg.byte_q),
        .io_sync_i(y_reg.io_s),
        .busy_o(eng_busy),
        .done_o(eng_done),
        .rbyte_o(eng_rbyte),
        .cmd_latch_o(cl),
        .addr_latch_o(al),
        .write_strobe_n_o(we_n),
        .read_strobe_n_o(rs_n),
        .io_out_o(io_o),
        .io_oe_o(oe)
    );

    // Pin bundle; chip enable is active low on the pin.
    assign pins_o = '{cmd_latch: cl, addr_latch: al, write_strobe_n: we_n,
        read_strobe_n: rs_n, chip_enable_n: !s_reg.ce, write_protect_n: s_reg.wp_n,
        io_out: io_o, io_oe: oe};
    assign rdata_o = s_reg.rdata;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence cmd_sent_s;
        cl && !we_n;
    endsequence

    cmd_known_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE15]
        cmd_sent_s |-> known_cmd(io_o)) else $error("undefined command on bus");
    busy_only_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE16]
        (wr_i && addr_i == `NSG_REG_CMD && wdata_i[9:8] == 2'(nsg_pkg::NSG_CYC_CMD) && dev_busy
        && !eng_busy && !s_reg.pending && req_cmd != `NSG_CMD_STATUS
        && req_cmd != `NSG_CMD_MSTATUS && req_cmd != `NSG_CMD_RESET) |=> !s_reg.pending)
        else $error("non-status command sent while busy");
    serial_follow_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE17]
        (cmd_sent_s and s_reg.after_serial) |-> (io_o != `NSG_CMD_ERASE_SETUP))
        else $error("illegal command after serial input");
    unused_zero_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE9]
        s_reg.sbyte[4:2] == 3'b000) else $error("unused status bits set");
    fail_mask_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE10]
        !stat.buf_ready |-> !stat.fail) else $error("fail shown while busy");
    wp_follow_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE21]
        (wr_i && addr_i == `NSG_REG_CTRL) |=> pins_o.write_protect_n == $past(wdata_i[`NSG_CTRL_WP_N]))
        else $error("write protect pin not updated");
    status_mode_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE20]
        (s_reg.in_status && !(wr_i && addr_i == `NSG_REG_CMD)) |=> s_reg.in_status)
        else $error("status mode left without command");
    addr_six_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE22]
        s_reg.addr_cnt <= 3'h6) else $error("too many address cycles");
    strobe_len_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE1]
        $fell(rs_n) |-> !rs_n [*2] ##1 rs_n) else $error("read strobe length wrong");
endmodule

// [sim/nsg_flash_model.sv]
// Behavioural model of the NAND device that answers the guard controller's pins.
`timescale 1ns/10ps
module nsg_flash_model (
    input wire logic clk_i,
    input wire nsg_pkg::nsg_pins_t pins_i,
    input wire logic fail_i,
    output logic [7:0] io_o,
    output logic ready_busy_n_o
);
    // --------------------------------------------------------------
    // Device state
    // --------------------------------------------------------------
    int busy_cnt = 60; // Power-up initialisation keeps the device busy for a while.
    logic prog_busy = 1'b0;
    logic status_mode = 1'b0;
    logic fail_q = 1'b0;
    logic [7:0] sbyte;

    // One busy count drives both ready bits, so they always agree here.
    // No cache program is modelled, so the previous page result always reads pass.
    assign sbyte = {pins_i.write_protect_n, busy_cnt == 0, busy_cnt == 0, 4'h0,
        fail_q};
    // Open-drain line: the pull-up wins whenever the device is not busy.
    assign ready_busy_n_o = (busy_cnt == 0);

    // --------------------------------------------------------------
    // Busy timing
    // --------------------------------------------------------------
    // The device has no clock; the bench clock only measures busy time.
    always @(posedge clk_i) begin
        if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
        if (prog_busy && !pins_i.write_protect_n) busy_cnt <= 0;
        if (busy_cnt <= 1) prog_busy <= 1'b0;
    end

    // --------------------------------------------------------------
    // Command latch
    // --------------------------------------------------------------
    // Address cycles, a sixth one included, are ignored by this model.
    always @(posedge pins_i.write_strobe_n) begin
        if (pins_i.cmd_latch && !pins_i.chip_enable_n) begin
            case (pins_i.io_out)
                8'h70, 8'h71: status_mode <= 1'b1;
                8'h00: status_mode <= 1'b0;
                8'hff: begin
                    status_mode <= 1'b0;
                    fail_q <= 1'b0;
                    prog_busy <= 1'b0;
                    busy_cnt <= 5;
                end
                8'h10, 8'hd0: if (pins_i.write_protect_n) begin
                    fail_q <= fail_i;
                    prog_busy <= 1'b1;
                    busy_cnt <= 80;
                end
                default: status_mode <= 1'b0;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Data output
    // --------------------------------------------------------------
    // Once the strobe rises the old byte is inverted, so stale data cannot match.
    initial io_o = 8'h5a;
    always @(pins_i.read_strobe_n) begin
        if (pins_i.read_strobe_n === 1'b0) io_o = status_mode ? sbyte : 8'ha5;
        else io_o = ~io_o;
    end
endmodule

// [sim/tb_nsg_ctrl.sv]
// Self-checking testbench for the NAND guard controller with a device model.
`timescale 1ns/10ps
`include "nsg_map.svh"
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
    end \
end
module tb_nsg_ctrl;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic clk_i;
    logic reset_i;
    logic [3:0] addr_i;
    logic [15:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [15:0] rdata_o;
    nsg_pkg::nsg_pins_t pins;
    logic [7:0] io_in;
    logic [7:0] flash_io;
    logic rb_n;
    logic fail;
    int compares = 0;
    int mismatches = 0;

    // The shared data pins carry whoever has them enabled.
    assign io_in = pins.io_oe ? pins.io_out : flash_io;

    nsg_ctrl dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .pins_o(pins),
        .io_in_i(io_in),
        .ready_busy_n_i(rb_n)
    );

    nsg_flash_model flash (
        .clk_i(clk_i),
        .pins_i(pins),
        .fail_i(fail),
        .io_o(flash_io),
        .ready_busy_n_o(rb_n)
    );

    // --------------------------------------------------------------
    // Register access tasks
    // --------------------------------------------------------------
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    // Polls one register bit; running out of tries ends the run.
    task automatic wait_bit(input logic [3:0] a, input int b, input logic val);
        logic [15:0] v;
        for (int n = 0; n < 300; n++) begin
            rd(a, v);
            if (v[b] === val) return;
        end
        mismatches++;
        $display("MISMATCH %0t wait on register bit ran out", $time);
        summarize();
    endtask

    // Issues one bus cycle, waits for the engine and checks the refusal flag.
    task automatic op(input logic [1:0] kind, input logic [7:0] b, input logic rej);
        logic [15:0] v;
        wr(`NSG_REG_CMD, {6'h00, kind, b});
        repeat (3) @(posedge clk_i);
        wait_bit(`NSG_REG_STATUS, 5, 1'b0);
        rd(`NSG_REG_STATUS, v);
        `CHK(v[7], rej)
    endtask

    task automatic check_sbyte(input logic [15:0] exp);
        logic [15:0] v;
        op(2'd3, 8'h00, 1'b0);
        rd(`NSG_REG_SBYTE, v);
        `CHK(v, exp)
    endtask

    // --------------------------------------------------------------
    // Clock and main sequence
    // --------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        logic [15:0] v;
        reset_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        fail = 1'b0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        `CHK(pins.write_protect_n, 1'b0)
        `CHK(pins.chip_enable_n, 1'b1)
        rd(`NSG_REG_CTRL, v);
        `CHK(v, 16'h0000)
        rd(`NSG_REG_STATUS, v);
        `CHK(v[1], 1'b0)
        op(2'd0, 8'h00, 1'b1);
        op(2'd0, 8'h70, 1'b0);
        wait_bit(`NSG_REG_STATUS, 1, 1'b1);
        // Chip enabled but protected: both ready bits set, unused bits clear.
        wr(`NSG_REG_CTRL, 16'h0002);
        op(2'd0, 8'h70, 1'b0);
        check_sbyte(16'h000c);
        op(2'd0, 8'h55, 1'b1);
        // Program with a failing result, six address cycles and a refused seventh.
        fail = 1'b1;
        wr(`NSG_REG_CTRL, 16'h0003);
        op(2'd0, 8'h80, 1'b0);
        for (int i = 0; i < 6; i++) op(2'd1, 8'(i), 1'b0);
        op(2'd1, 8'h06, 1'b1);
        op(2'd0, 8'h30, 1'b1);
        op(2'd0, 8'h10, 1'b0);
        wait_bit(`NSG_REG_STATUS, 4, 1'b1);
        op(2'd0, 8'h00, 1'b1);
        op(2'd0, 8'h70, 1'b0);
        check_sbyte(16'h0010);
        wait_bit(`NSG_REG_STATUS, 4, 1'b0);
        check_sbyte(16'h001d);
        // Reset clears the failed result.
        op(2'd0, 8'hff, 1'b0);
        rd(`NSG_REG_STATUS, v);
        `CHK(v[6], 1'b0)
        wait_bit(`NSG_REG_STATUS, 4, 1'b0);
        op(2'd0, 8'h70, 1'b0);
        check_sbyte(16'h001c);
        // Status mode holds until the read command returns to data output.
        rd(`NSG_REG_STATUS, v);
        `CHK(v[6], 1'b1)
        op(2'd0, 8'h00, 1'b0);
        rd(`NSG_REG_STATUS, v);
        `CHK(v[6], 1'b0)
        op(2'd3, 8'h00, 1'b0);
        rd(`NSG_REG_DATA, v);
        `CHK(v, 16'h00a5)
        rd(4'hf, v);
        summarize();
    end
endmodule
